// ==== core/base_mem_pkg.sv ====
package base_mem_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] BASE_MEMORY_CONTROL_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] BASE_MEMORY_STATUS_OFFSET = 8'h04;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_WRITE_MASK = 32'h0fc0_c0fb;

    // ----------------------------------------------------------------
    // Control field positions
    // ----------------------------------------------------------------
    localparam int TYPE_LSB = 0;
    localparam int ENABLE_BIT = 3;
    localparam int SPLIT_LSB = 4;
    localparam int INTERLEAVE_BIT = 6;
    localparam int PAGE_HOLD_BIT = 7;
    localparam int MASK_LSB = 14;
    localparam int BASE_LSB = 22;

    // ----------------------------------------------------------------
    // Status field positions
    // ----------------------------------------------------------------
    localparam int ST_PAGE_OPEN_BIT = 0;
    localparam int ST_TYPE_INVALID_BIT = 1;
    localparam int ST_SDRAM_CONFLICT_BIT = 2;
    localparam int ST_LAST_HIT_BIT = 3;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] MEM_TYPE_EDO = 2'h0;
    localparam logic [1:0] MEM_TYPE_SDRAM = 2'h3;
    localparam logic [1:0] SDRAM_SPLIT_MODE = 2'h3;
    localparam int WORD_ADDR_BIT = 2;
    localparam int PAGE_ADDR_BIT = 28;
    localparam int CMP_LSB = 22;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : base_mem_pkg

// ==== core/base_cfg_if.sv ====
interface base_cfg_if;
    logic [1:0] mem_type;
    logic enable;
    logic [1:0] addr_split_select;
    logic interleave;
    logic page_hold_bit;
    logic [1:0] size_mask;
    logic [5:0] region_base_field;

    modport source (
        output mem_type, enable, addr_split_select, interleave,
        output page_hold_bit, size_mask, region_base_field
    );
    modport sink (
        input mem_type, enable, addr_split_select, interleave,
        input page_hold_bit, size_mask, region_base_field
    );
endinterface : base_cfg_if

// ==== core/region_match.sv ====
module region_match
    import base_mem_pkg::*;
(
    base_cfg_if.sink cfg,
    input wire logic [31:0] phys_addr_in,
    output logic hit_out
);

    // ----------------------------------------------------------------
    // Base compare
    // ----------------------------------------------------------------
    logic [5:0] cmp_mask;
    logic [5:0] diff;

    // Mask bit 0 drops the matching address bit from the compare
    assign cmp_mask = {4'hf, cfg.size_mask};
    // Bits 27:22 only, so bit 28 aliases
    assign diff = phys_addr_in[CMP_LSB+5:CMP_LSB] ^ cfg.region_base_field;
    assign hit_out = cfg.enable && ((diff & cmp_mask) == 6'h00);

endmodule : region_match

// ==== core/page_keeper.sv ====
module page_keeper
    import base_mem_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    base_cfg_if.sink cfg,
    input wire logic access_in,
    input wire logic hit_in,
    input wire logic page_bit_in,
    output logic row_strobe_n_out,
    output logic page_open_out
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic in_cycle;
        logic keep;
        logic page_open;
        logic row_strobe_n;
    } page_state_t;

    page_state_t st;
    page_state_t next_st;

    // Row strobe low through a hit cycle, then held or released
    always_comb
    begin
        next_st = st;
        if (access_in && hit_in && !st.in_cycle)
        begin
            next_st.in_cycle = 1'b1;
            next_st.keep = cfg.page_hold_bit && page_bit_in;
        end
        else if (st.in_cycle && !access_in)
        begin
            next_st.in_cycle = 1'b0;
            next_st.page_open = st.keep;
        end
        if (!cfg.enable)
        begin
            next_st.page_open = 1'b0;
        end
        next_st.row_strobe_n = !(next_st.in_cycle || next_st.page_open);
    end

    // State register
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            st <= '{in_cycle: 1'b0, keep: 1'b0, page_open: 1'b0, row_strobe_n: 1'b1};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign row_strobe_n_out = st.row_strobe_n;
    assign page_open_out = st.page_open;

endmodule : page_keeper

// ==== core/base_memory_config_decode.sv ====
// Function
// - Type field: 0 EDO, 3 SDRAM
// - Bit 3 enables base memory range
// - Two-bit address split mode, SDRAM uses 3
// - Interleave: even words bus A, odd B
// - No interleave: first data bus only
// - Page hold set keeps row strobe asserted
// - Page hold clear negates row strobe
// - Address bit 28 low closes page
// - Size mask excludes address bits 23:22
// - Address bit 28 ignored by compare
// - Base field compared with bits 27:22
// - Control register resets to zero
// - Control register at offset zero
module base_memory_config_decode
    import base_mem_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic access_in,
    input wire logic [31:0] phys_addr_in,
    output logic base_hit_out,
    output logic even_data_bus_out,
    output logic odd_data_bus_out,
    output logic sdram_select_out,
    output logic [1:0] addr_split_select_out,
    output logic row_strobe_n_out
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] ctrl;
        logic last_hit;
        logic hit;
        logic even_sel;
        logic odd_sel;
        logic sdram;
        logic [1:0] split;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;

    base_cfg_if cfg_bus ();

    logic hit;
    logic page_open;
    logic type_invalid;
    logic sdram_conflict;
    logic [31:0] status_word;
    logic [31:0] merged;
    logic [31:0] lane_word;

    // ----------------------------------------------------------------
    // Configuration fields onto the internal carrier
    // ----------------------------------------------------------------
    // Reserved bits never reach the carrier, so they cannot steer decode
    assign cfg_bus.mem_type = st.ctrl[TYPE_LSB+1:TYPE_LSB];
    assign cfg_bus.enable = st.ctrl[ENABLE_BIT];
    assign cfg_bus.addr_split_select = st.ctrl[SPLIT_LSB+1:SPLIT_LSB];
    assign cfg_bus.interleave = st.ctrl[INTERLEAVE_BIT];
    assign cfg_bus.page_hold_bit = st.ctrl[PAGE_HOLD_BIT];
    assign cfg_bus.size_mask = st.ctrl[MASK_LSB+1:MASK_LSB];
    assign cfg_bus.region_base_field = st.ctrl[BASE_LSB+5:BASE_LSB];

    // ----------------------------------------------------------------
    // Address decode and page control
    // ----------------------------------------------------------------
    // Compare is combinational, so a hit is known in the first access cycle
    // Enable gates the hit, so a disabled range never answers
    region_match u_match (
        .cfg(cfg_bus.sink),
        .phys_addr_in(phys_addr_in),
        .hit_out(hit)
    );

    // Hold bit and address bit 28 are latched when the access starts
    // A cleared enable closes any open page at once
    page_keeper u_page (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .cfg(cfg_bus.sink),
        .access_in(access_in),
        .hit_in(hit),
        .page_bit_in(phys_addr_in[PAGE_ADDR_BIT]),
        .row_strobe_n_out(row_strobe_n_out),
        .page_open_out(page_open)
    );

    // ----------------------------------------------------------------
    // Configuration checks for status
    // ----------------------------------------------------------------
    // Encodings 1 and 2 are flagged as invalid
    // The field keeps what was written; the flag is the only effect
    assign type_invalid = (cfg_bus.mem_type != MEM_TYPE_EDO)
        && (cfg_bus.mem_type != MEM_TYPE_SDRAM);

    // SDRAM with interleave, page hold or a split mode other than 3
    // These are software duties, so the block reports rather than blocks
    assign sdram_conflict = (cfg_bus.mem_type == MEM_TYPE_SDRAM)
        && (cfg_bus.interleave || cfg_bus.page_hold_bit
        || (cfg_bus.addr_split_select != SDRAM_SPLIT_MODE));

    // ----------------------------------------------------------------
    // Status register
    // ----------------------------------------------------------------
    // Status word, other bits zero
    // Read-only: a write to it answers OKAY and changes nothing
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[ST_PAGE_OPEN_BIT] = page_open;
        status_word[ST_TYPE_INVALID_BIT] = type_invalid;
        status_word[ST_SDRAM_CONFLICT_BIT] = sdram_conflict;
        status_word[ST_LAST_HIT_BIT] = st.last_hit;
    end

    // ----------------------------------------------------------------
    // Control write merge
    // ----------------------------------------------------------------
    // Byte-lane merge of write data into the control word
    for (genvar lane = 0; lane < 4; lane++)
    begin : g_lane
        // A lane without its strobe keeps the stored byte
        assign lane_word[lane*8 +: 8] = st.w_strb[lane]
            ? st.w_data[lane*8 +: 8] : st.ctrl[lane*8 +: 8];
    end

    // Reserved positions never store a one
    assign merged = lane_word & CTRL_WRITE_MASK;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_st = st;

        // Write address and data taken in either order
        // Readies drop once a half is held, so a second one waits its turn
        if (s_axi_awvalid_in && s_axi_awready_out)
        begin
            next_st.aw_have = 1'b1;
            next_st.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out)
        begin
            next_st.w_have = 1'b1;
            next_st.w_data = s_axi_wdata_in;
            next_st.w_strb = s_axi_wstrb_in;
        end

        // Both halves held: perform the write and answer
        // An unmapped write answers with an error and stores nothing
        if (st.aw_have && st.w_have && !st.bvalid)
        begin
            next_st.aw_have = 1'b0;
            next_st.w_have = 1'b0;
            next_st.bvalid = 1'b1;
            if (st.aw_addr == BASE_MEMORY_CONTROL_OFFSET)
            begin
                next_st.ctrl = merged;
                next_st.bresp = RESP_OKAY;
            end
            else if (st.aw_addr == BASE_MEMORY_STATUS_OFFSET)
            begin
                next_st.bresp = RESP_OKAY;
            end
            else
            begin
                next_st.bresp = RESP_SLVERR;
            end
        end
        else if (st.bvalid && s_axi_bready_in)
        begin
            next_st.bvalid = 1'b0;
        end

        // ------------------------------------------------------------
        // Read channel
        // ------------------------------------------------------------
        // Read address taken straight into the data register
        // Status is captured at the address edge, not when data is taken
        if (s_axi_arvalid_in && s_axi_arready_out)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            if (s_axi_araddr_in == BASE_MEMORY_CONTROL_OFFSET)
            begin
                next_st.rdata = st.ctrl & CTRL_WRITE_MASK;
            end
            else if (s_axi_araddr_in == BASE_MEMORY_STATUS_OFFSET)
            begin
                next_st.rdata = status_word;
            end
            else
            begin
                next_st.rdata = 32'h0000_0000;
                next_st.rresp = RESP_SLVERR;
            end
        end
        else if (st.rvalid && s_axi_rready_in)
        begin
            next_st.rvalid = 1'b0;
        end

        // ------------------------------------------------------------
        // Access decode
        // ------------------------------------------------------------
        // Registered decode outputs for each access cycle
        // Last hit only moves on edges where an access is sampled
        next_st.hit = access_in && hit;
        if (access_in)
        begin
            next_st.last_hit = hit;
        end
        // The word bit picks the bus only while interleave is on
        next_st.even_sel = access_in && hit
            && (!cfg_bus.interleave
            || !phys_addr_in[WORD_ADDR_BIT]);
        next_st.odd_sel = access_in && hit && cfg_bus.interleave
            && phys_addr_in[WORD_ADDR_BIT];
        // Configuration outputs trail a control write by one cycle
        next_st.sdram = cfg_bus.mem_type == MEM_TYPE_SDRAM;
        next_st.split = cfg_bus.addr_split_select;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Reset clears the control word, which also turns the range off
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            st <= '0;
            st.ctrl <= CTRL_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Handshake readies held off while a half is pending
    // Write readies also drop while the answer waits: one write at a time
    assign s_axi_awready_out = !st.aw_have && !st.bvalid;
    assign s_axi_wready_out = !st.w_have && !st.bvalid;
    assign s_axi_arready_out = !st.rvalid;
    assign s_axi_bvalid_out = st.bvalid;
    assign s_axi_bresp_out = st.bresp;
    assign s_axi_rvalid_out = st.rvalid;
    assign s_axi_rdata_out = st.rdata;
    assign s_axi_rresp_out = st.rresp;

    // ----------------------------------------------------------------
    // Decode outputs
    // ----------------------------------------------------------------
    // Decode and configuration outputs straight from flip-flops
    assign base_hit_out = st.hit;
    assign even_data_bus_out = st.even_sel;
    assign odd_data_bus_out = st.odd_sel;
    assign sdram_select_out = st.sdram;
    assign addr_split_select_out = st.split;

endmodule : base_memory_config_decode

// ==== dv/base_memory_config_decode_asserts.sv ====
// ----------------------------------------------------------------
// Port checks for the base memory decoder
// ----------------------------------------------------------------
module base_memory_config_decode_asserts (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic access_in,
    input wire logic [31:0] phys_addr_in,
    input wire logic base_hit_out,
    input wire logic even_data_bus_out,
    input wire logic odd_data_bus_out,
    input wire logic row_strobe_n_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    // Both write channels taken at one edge
    sequence seq_write_taken;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    // Hit access with page bit low, then the cycle ends
    sequence seq_page_drop;
        base_hit_out && access_in && !phys_addr_in[28] ##1 !access_in;
    endsequence

    chk_write_answer: assert property (seq_write_taken |=> ##1 s_axi_bvalid_out)
        else $error("write response missing");
    chk_bresp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
        else $error("write response dropped early");
    chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read data missing");
    chk_rdata_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data changed before taken");
    chk_hit_from_access: assert property (base_hit_out |-> $past(access_in))
        else $error("hit without access");
    chk_idle_no_hit: assert property (!access_in |=> !base_hit_out)
        else $error("hit while idle");
    chk_odd_word: assert property (odd_data_bus_out |-> base_hit_out && $past(phys_addr_in[2]))
        else $error("odd bus on even word");
    chk_bus_pick: assert property (base_hit_out |-> even_data_bus_out != odd_data_bus_out)
        else $error("data bus choice wrong");
    chk_strobe_on_hit: assert property (base_hit_out |-> !row_strobe_n_out)
        else $error("row strobe high during hit");
    chk_page_close: assert property (seq_page_drop |-> ##[1:2] row_strobe_n_out)
        else $error("page left open");
endmodule : base_memory_config_decode_asserts

bind base_memory_config_decode base_memory_config_decode_asserts base_memory_config_decode_asserts_i (
    .mclk_in(mclk_in), .rst_in(rst_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
    .s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
    .access_in(access_in), .phys_addr_in(phys_addr_in), .base_hit_out(base_hit_out),
    .even_data_bus_out(even_data_bus_out), .odd_data_bus_out(odd_data_bus_out),
    .row_strobe_n_out(row_strobe_n_out));

// ==== dv/base_mem_array_model.sv ====
// ----------------------------------------------------------------
// Base memory array: counts row openings
// ----------------------------------------------------------------
module base_mem_array_model (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic row_strobe_n_in,
    output logic [7:0] row_opens_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic strobe_d;

    // A falling row strobe opens a new row in the array
    always_ff @(posedge mclk_in)
    begin
        strobe_d <= row_strobe_n_in;
        if (rst_in)
            row_opens_out <= 8'h00;
        else if (strobe_d && !row_strobe_n_in)
            row_opens_out <= row_opens_out + 8'h01;
    end
endmodule : base_mem_array_model

// ==== dv/base_memory_config_decode_bench.sv ====
module base_memory_config_decode_bench import base_mem_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in = 1'h0, rst_in = 1'h1, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, access = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, opens, o;
    logic [31:0] wdata = 32'h0, paddr = 32'h0, rdata, cfg, a;
    logic awready, wready, bvalid, arready, rvalid, hit, even, odd, sdram, rsn;
    logic [1:0] bresp, rresp, split, m;
    int failures = 0, checks_done = 0, seed = 32'h1c22;

    // Free-running clock
    always #4 mclk_in = ~mclk_in;

    base_memory_config_decode base_memory_config_decode_i (
        .mclk_in(mclk_in), .rst_in(rst_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .access_in(access), .phys_addr_in(paddr), .base_hit_out(hit), .even_data_bus_out(even),
        .odd_data_bus_out(odd), .sdram_select_out(sdram), .addr_split_select_out(split),
        .row_strobe_n_out(rsn));

    base_mem_array_model base_mem_array_model_i (
        .mclk_in(mclk_in), .rst_in(rst_in), .row_strobe_n_in(rsn), .row_opens_out(opens));

    // ----------------------------------------------------------------
    // Bus, access and checking tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic exp_hit(input logic [31:0] c, input logic [31:0] ad);
        return c[3] && (((ad[27:22] ^ c[27:22]) & {4'hf, c[15:14]}) == 6'h00);
    endfunction : exp_hit

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge mclk_in);
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
            if (bvalid && bready)
            begin
                check(bresp, RESP_OKAY);
                bready <= 1'h0;
            end
        end
        while (awvalid || wvalid || bready);
        cfg = d & CTRL_WRITE_MASK;
    endtask : wr

    task automatic rd(input logic [7:0] ad, input logic [31:0] ed, input logic [1:0] er);
        araddr <= ad;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge mclk_in);
            if (arvalid && arready)
                arvalid <= 1'h0;
            if (rvalid && rready)
            begin
                check(rdata, ed);
                check(rresp, er);
                rready <= 1'h0;
            end
        end
        while (arvalid || rready);
    endtask : rd

    // Two-cycle memory access, then page state after it ends
    task automatic acc(input logic [31:0] ad);
        logic h, e;
        paddr <= ad;
        access <= 1'h1;
        repeat (2) @(posedge mclk_in);
        access <= 1'h0;
        #1;
        h = exp_hit(cfg, ad);
        e = h && !(cfg[6] && ad[2]);
        check(hit, h);
        check({even, odd}, {e, h && !e});
        repeat (3) @(posedge mclk_in);
        check(rsn, !(h && cfg[7] && ad[28]));
    endtask : acc

    task automatic summarize;
        if (failures == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'h0;
        @(posedge mclk_in);
        rd(8'h00, 32'h0, RESP_OKAY);
        rd(8'h08, 32'h0, RESP_SLVERR);
        wr(8'h00, 32'hffff_ffff);
        rd(8'h00, 32'h0fc0_c0fb, RESP_OKAY);
        rd(8'h04, 32'h0000_0004, RESP_OKAY);
        for (int t = 0; t < 4; t++)
        begin
            wr(8'h00, {26'h0, t[1:0], 2'h0, t[1:0]});
            check(sdram, t == 3);
            check(split, t[1:0]);
            rd(8'h04, {30'h0, t[0] ^ t[1], 1'h0}, RESP_OKAY);
        end
        for (int i = 0; i < 60; i++)
        begin
            a = $random(seed);
            m = a[15] ? {1'h1, a[14]} : 2'h0;
            wr(8'h00, (a & 32'h0fc0_0078) | {16'h0, m, 14'h0});
            rd(8'h00, cfg, RESP_OKAY);
            a = $random(seed);
            if (a[0])
                a[27:22] = cfg[27:22] ^ {4'h0, a[9:8]};
            acc(a);
        end
        wr(8'h00, 32'h0000_0088);
        acc(32'h1000_0000);
        o = opens;
        acc(32'h1000_0004);
        check(opens, o);
        rst_in <= 1'h1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'h0;
        @(posedge mclk_in);
        check(rsn, 1'h1);
        rd(8'h00, CTRL_RESET, RESP_OKAY);
        wr(8'h00, 32'h0000_0088);
        acc(32'h0000_0004);
        summarize();
    end

    initial
    begin
        #200000;
        failures++;
        summarize();
    end
endmodule : base_memory_config_decode_bench
